// ===== hw/host_touch_consts.vh
// Constants for the host-driven touch input block: register map,
// field positions, reset values and timing.
// Assumes inclusion by bare name from plain Verilog-2005 design files.
`ifndef HOST_TOUCH_CONSTS_VH
`define HOST_TOUCH_CONSTS_VH

// ***************************************************************
// Register byte addresses (low 22 bits of haddr)
// ***************************************************************
`define ADDR_TOUCH_X_RAW    22'h30210c
`define ADDR_TOUCH_ID_PHASE 22'h302114
`define ADDR_TOUCH_Y_RAW    22'h302118
`define ADDR_TOUCH_ACK      22'h302170
`define ADDR_ENGINE_RESET   22'h302000
`define ADDR_TOUCH_CONFIG   22'h302004
`define ADDR_MODE_SELECT    22'h302008
`define ADDR_IRQ_STATUS     22'h30200c
`define ADDR_IRQ_MASK       22'h302010
`define ADDR_RESULT_BASE    22'h302200
`define ADDR_RESULT_LAST    22'h302210
`define ADDR_HI_BIT         21

// ***************************************************************
// Fields and values
// ***************************************************************
`define CFG_HOST_BIT        14
`define ENGINE_RESET_BIT    1
`define ID_COMMIT           4'hf
`define NO_TOUCH            16'h8000
`define ACK_DONE            4'h1
`define ACK_BUSY            4'h0
`define MAX_TOUCHES         5
`define RESET_ENGINE_VAL    2'h2
`define TOUCH_X_RESET       16'h8000
`define TOUCH_Y_RESET       16'h8000

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_MHZ             40
`define CONV_LIMIT_US       1000
`define CONV_CYCLES_PER_ID  4

`endif

// ===== hw/host_touch_input.v
// Host-driven multi-touch input: AHB-Lite register slave, touch
// staging slots, commit-triggered conversion, ack and interrupt.
// Assumes a single AHB-Lite master issuing single word transfers.
//
// Behaviour
// - Device has X, Y 16-bit, id 4-bit and ack 4-bit registers.
// - Up to five touches with identifiers 0 to 4.
// - X and Y both 0x8000 means no touch.
// - Commit 0xf clears ack, then converts all supplied slots in extended mode, only slot 0 in compatibility mode.
// - At conversion end ack becomes 1 and done flag is set.
// - Conversion of a committed set finishes well under 1 ms.
// - Extended mode accepts identifiers of a set in any order.
// - Extended mode treats unwritten identifiers as not pressed.
// - Works in both modes; engine reset after mode change.
`timescale 1ns/100ps
`include "host_touch_consts.vh"

module host_touch_input
#(
   parameter N_TOUCH = `MAX_TOUCHES
)
(
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Interrupt
   output wire        irq
);

   // ***************************************************************
   // Local constants and state codes
   // ***************************************************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_CONV = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;
   localparam [2:0] SLOT_W  = 3;
   localparam integer CONV_CYC = N_TOUCH * `CONV_CYCLES_PER_ID;
   localparam integer LIMIT_CYC = `CONV_LIMIT_US * `CLK_MHZ;

   // ***************************************************************
   // Bus address phase capture
   // ***************************************************************
   reg         wr_q;
   reg         rd_q;
   reg  [21:0] addr_q;
   wire        take = hsel & hready & htrans[1];

   // Every access completes in one data phase, never an error.
   // Transfer size is not decoded: only whole aligned words are
   // served, so a narrower write lands as a full word.
   // The address is kept every cycle; it only matters when the
   // write or read strobe captured with it is set.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 22'h000000;
      end
      else
      begin
         wr_q   <= take & hwrite;
         rd_q   <= take & ~hwrite;
         addr_q <= haddr[`ADDR_HI_BIT:0];
      end
   end

   // ***************************************************************
   // Host-written registers
   // ***************************************************************
   reg  [15:0] x_raw_q;
   reg  [15:0] y_raw_q;
   reg  [3:0]  id_q;
   reg  [3:0]  ack_q;
   reg  [1:0]  eng_rst_q;
   reg  [15:0] cfg_q;
   reg         mode_ext_q;
   reg         irq_stat_q;
   reg         irq_mask_q;
   reg  [2:0]  state_q;
   reg  [7:0]  cnt_q;

   wire w_x    = wr_q & (addr_q == `ADDR_TOUCH_X_RAW);
   wire w_y    = wr_q & (addr_q == `ADDR_TOUCH_Y_RAW);
   wire w_id   = wr_q & (addr_q == `ADDR_TOUCH_ID_PHASE);
   wire w_rst  = wr_q & (addr_q == `ADDR_ENGINE_RESET);
   wire w_cfg  = wr_q & (addr_q == `ADDR_TOUCH_CONFIG);
   wire w_mode = wr_q & (addr_q == `ADDR_MODE_SELECT);
   wire w_stat = wr_q & (addr_q == `ADDR_IRQ_STATUS);
   wire w_mask = wr_q & (addr_q == `ADDR_IRQ_MASK);

   wire eng_rst  = eng_rst_q[`ENGINE_RESET_BIT];
   wire host_on  = cfg_q[`CFG_HOST_BIT] & ~eng_rst;
   wire commit   = w_id & (hwdata[3:0] == `ID_COMMIT) & host_on;
   wire id_valid = (hwdata[3:0] < N_TOUCH);
   wire conv_end = (state_q == ST_CONV) & (cnt_q == 8'h00);

   // Raw coordinate holding registers, written in any order
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         x_raw_q <= `TOUCH_X_RESET;
         y_raw_q <= `TOUCH_Y_RESET;
         id_q    <= 4'h0;
      end
      else
      begin
         if (w_x)
            x_raw_q <= hwdata[15:0];
         if (w_y)
            y_raw_q <= hwdata[15:0];
         if (w_id)
            id_q <= hwdata[3:0];
      end
   end

   // Control: engine reset, config, mode select, mask
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         eng_rst_q  <= 2'h0;
         cfg_q      <= 16'h0000;
         mode_ext_q <= 1'b0;
         irq_mask_q <= 1'b0;
      end
      else
      begin
         if (w_rst)
            eng_rst_q <= hwdata[1:0];
         if (w_cfg)
            cfg_q <= hwdata[15:0];
         if (w_mode)
            mode_ext_q <= hwdata[0];
         if (w_mask)
            irq_mask_q <= hwdata[0];
      end
   end

   // ***************************************************************
   // Staging slots, one per identifier
   // ***************************************************************
   // Staged values live apart from results so partial sets never show
   reg  [15:0] stg_x_q [0:N_TOUCH-1];
   reg  [15:0] stg_y_q [0:N_TOUCH-1];
   reg  [15:0] res_x_q [0:N_TOUCH-1];
   reg  [15:0] res_y_q [0:N_TOUCH-1];
   reg  [N_TOUCH-1:0] written_q;

   genvar g;
   generate
      for (g = 0; g < N_TOUCH; g = g + 1)
      begin : slot
         wire hit = w_id & id_valid & host_on
                    & (hwdata[SLOT_W-1:0] == g);
         wire pressed = written_q[g]
                        & ~((stg_x_q[g] == `NO_TOUCH)
                        & (stg_y_q[g] == `NO_TOUCH));
         // Compatibility mode keeps only slot zero live
         wire live = mode_ext_q | (g == 0);

         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               stg_x_q[g]   <= `NO_TOUCH;
               stg_y_q[g]   <= `NO_TOUCH;
               written_q[g] <= 1'b0;
               res_x_q[g]   <= `NO_TOUCH;
               res_y_q[g]   <= `NO_TOUCH;
            end
            else
            begin
               if (eng_rst)
                  written_q[g] <= 1'b0;
               else if (hit)
               begin
                  stg_x_q[g]   <= x_raw_q;
                  stg_y_q[g]   <= y_raw_q;
                  written_q[g] <= 1'b1;
               end
               else if (conv_end)
                  written_q[g] <= 1'b0;    // next set starts empty
               // Results move only when a committed set converts
               if (conv_end)
               begin
                  if (pressed & live)
                  begin
                     res_x_q[g] <= stg_x_q[g];
                     res_y_q[g] <= stg_y_q[g];
                  end
                  else
                  begin
                     res_x_q[g] <= `NO_TOUCH;
                     res_y_q[g] <= `NO_TOUCH;
                  end
               end
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Conversion sequencer
   // ***************************************************************
   // Fixed short latency keeps far inside the conversion time limit.
   // A commit that arrives while a set is converting is dropped;
   // the host is expected to wait for the acknowledge first.
   // Engine reset aborts a conversion and reports ready again, so
   // a host polling the acknowledge never hangs across a reset.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 8'h00;
         ack_q   <= `ACK_DONE;
      end
      else if (eng_rst)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 8'h00;
         ack_q   <= `ACK_DONE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (commit)
               begin
                  ack_q   <= `ACK_BUSY;
                  cnt_q   <= CONV_CYC[7:0];
                  state_q <= ST_CONV;
               end
            end
            ST_CONV:
            begin
               if (cnt_q == 8'h00)
                  state_q <= ST_DONE;
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            ST_DONE:
            begin
               ack_q   <= `ACK_DONE;
               state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Interrupt status, set wins over write-one-to-clear
   // ***************************************************************
   wire done_evt = (state_q == ST_DONE);

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_stat_q <= 1'b0;
      else if (done_evt)
         irq_stat_q <= 1'b1;
      else if (w_stat & hwdata[0])
         irq_stat_q <= 1'b0;
   end

   assign irq = irq_stat_q & irq_mask_q;

   // ***************************************************************
   // Read data
   // ***************************************************************
   wire [21:0] roff = haddr[`ADDR_HI_BIT:0] - `ADDR_RESULT_BASE;
   wire [2:0]  ridx = roff[4:2];
   reg  [31:0] rd_d;

   // Decoded in the address phase; unmapped addresses read zero.
   // Result words pack X in the upper half and Y in the lower.
   always @*
   begin
      rd_d = 32'h00000000;
      if (haddr[`ADDR_HI_BIT:0] == `ADDR_TOUCH_X_RAW)
         rd_d = {16'h0000, x_raw_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_TOUCH_Y_RAW)
         rd_d = {16'h0000, y_raw_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_TOUCH_ID_PHASE)
         rd_d = {28'h0000000, id_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_TOUCH_ACK)
         rd_d = {28'h0000000, ack_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_ENGINE_RESET)
         rd_d = {30'h00000000, eng_rst_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_TOUCH_CONFIG)
         rd_d = {16'h0000, cfg_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_MODE_SELECT)
         rd_d = {31'h00000000, mode_ext_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_IRQ_STATUS)
         rd_d = {31'h00000000, irq_stat_q};
      else if (haddr[`ADDR_HI_BIT:0] == `ADDR_IRQ_MASK)
         rd_d = {31'h00000000, irq_mask_q};
      else if ((haddr[`ADDR_HI_BIT:0] >= `ADDR_RESULT_BASE)
               && (haddr[`ADDR_HI_BIT:0] <= `ADDR_RESULT_LAST)
               && (haddr[1:0] == 2'b00)
               && (ridx < N_TOUCH))
         rd_d = {res_x_q[ridx], res_y_q[ridx]};
   end

   // Registered read data stands in the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (take & ~hwrite)
         hrdata <= rd_d;
   end

endmodule // host_touch_input

// ===== verification/host_mcu_model.sv
// Host microcontroller model: AHB-Lite master feeding touch sets.
// Assumes hready is the slave's hreadyout.
`timescale 1ns/100ps
`include "host_touch_consts.vh"
module host_mcu_model
(
   // Bus
   input  wire        hclk,
   input  wire        hready,
   input  wire [31:0] hrdata,
   output reg         hsel,
   output reg  [31:0] haddr,
   output reg  [1:0]  htrans,
   output reg         hwrite,
   output reg  [2:0]  hsize,
   output reg  [31:0] hwdata
);
   integer gap = 0; // Idle cycles before a transfer, for a slow host
   // Bus idle at start; size always a whole word
   initial
   begin
      hsel   = 1'b0;
      haddr  = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h00000000;
   end
   // Single word transfer, entered just after a rising edge
   task xfer(input w, input [21:0] a, input [31:0] wd,
             output [31:0] rd);
      begin
         repeat (gap) @(posedge hclk);
         hsel   <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr  <= {10'h000, a};
         @(posedge hclk);
         while (!hready) @(posedge hclk);
         htrans <= 2'h0;
         hsel   <= 1'b0;
         hwdata <= w ? wd : ~hwdata; // Released data shows no old value
         @(posedge hclk);
         while (!hready) @(posedge hclk);
         rd = hrdata;
      end
   endtask
   task wr(input [21:0] a, input [31:0] d);
      reg [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task rd(input [21:0] a, output [31:0] d);
      xfer(1'b0, a, 32'h0, d);
   endtask
   // Hold engine, set host bit, pick mode, release the engine
   task enter(input m);
      begin
         wr(`ADDR_ENGINE_RESET, 32'h2);
         wr(`ADDR_TOUCH_CONFIG, 32'h4000);
         wr(`ADDR_MODE_SELECT, {31'h0, m});
         wr(`ADDR_ENGINE_RESET, 32'h0);
      end
   endtask
   // One touch as fetched from the panel: X, Y, then identifier
   task touch(input [3:0] id, input [15:0] x, input [15:0] y);
      begin
         wr(`ADDR_TOUCH_X_RAW, {16'h0, x});
         wr(`ADDR_TOUCH_Y_RAW, {16'h0, y});
         wr(`ADDR_TOUCH_ID_PHASE, {28'h0, id});
      end
   endtask
   // Confirm the last set was taken, then commit
   task commit;
      reg [31:0] r;
      integer    n;
      begin
         r = 32'h0;
         for (n = 0; n < 100 && r[3:0] != `ACK_DONE; n = n + 1)
            rd(`ADDR_TOUCH_ACK, r);
         wr(`ADDR_TOUCH_ID_PHASE, {28'h0, `ID_COMMIT});
      end
   endtask
endmodule // host_mcu_model

// ===== verification/host_touch_checker_assertions.sv
// Checker for the host touch block: bus answer, ack and irq timing.
// Assumes one master, hready tied to hreadyout.
`timescale 1ns/100ps
`include "host_touch_consts.vh"
module host_touch_checker
#(
   parameter N_TOUCH = 5
)
(
   // Bus and interrupt
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire        irq
);
   reg        rd_q;
   reg        wr_q;
   reg [21:0] a_q;
   reg [5:0]  c_q;
   wire       cmt;
   // Commit seen in its data phase
   assign cmt = wr_q && a_q == `ADDR_TOUCH_ID_PHASE
                && hwdata[3:0] == `ID_COMMIT;
   // Data phase tracking; c_q counts cycles since commit, back to 0 after 40
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         a_q  <= 22'h0;
         c_q  <= 6'h00;
      end
      else
      begin
         if (hready)
         begin
            rd_q <= hsel && htrans[1] && !hwrite;
            wr_q <= hsel && htrans[1] && hwrite;
            a_q  <= haddr[21:0];
         end
         c_q <= cmt ? 6'h01 : (c_q != 6'h00 && c_q < 6'h28) ?
                c_q + 6'h01 : 6'h00;
      end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_commit;
      cmt;
   endsequence
   sequence s_ack_rd;
      rd_q && a_q == `ADDR_TOUCH_ACK;
   endsequence
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_rdata_holds: assert property (!(hready && hsel && htrans[1] && !hwrite)
      |=> $stable(hrdata)) else $error("hrdata moved");
   a_unmapped_zero: assert property (rd_q && a_q == 22'h302300
      |-> hrdata == 32'h0) else $error("unmapped read not zero");
   a_ack_busy: assert property (s_ack_rd ##0 (c_q >= 2 && c_q <= 21)
      |-> hrdata[3:0] == `ACK_BUSY) else $error("ack not cleared");
   a_ack_done: assert property (s_ack_rd ##0 (c_q >= 26 && c_q <= 39)
      |-> hrdata[3:0] == `ACK_DONE) else $error("ack not set");
   a_irq_late: assert property (s_commit |=> !$rose(irq) [*8])
      else $error("irq before conversion");
   a_irq_clear: assert property (wr_q && a_q == `ADDR_IRQ_STATUS
      && hwdata[0] && (c_q == 0 || c_q > 26) |=> !irq)
      else $error("irq not cleared");
   a_mask_gate: assert property (wr_q && a_q == `ADDR_IRQ_MASK
      && !hwdata[0] |=> !irq) else $error("masked irq high");
endmodule // host_touch_checker

bind host_touch_input host_touch_checker #(.N_TOUCH(N_TOUCH)) chk_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .irq(irq));

// ===== verification/host_touch_input_tb_top.sv
// Testbench for the host touch block: registers, conversion, irq.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/100ps
`include "host_touch_consts.vh"
module host_touch_input_tb_top;
   reg         hclk = 1'b0;
   reg         hresetn = 1'b0;
   wire        hsel, hwrite, hreadyout, hresp, irq;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0]  htrans;
   wire [2:0]  hsize;
   integer     num_errors = 0;
   integer     checked = 0;
   integer     n;
   reg  [31:0] r;
   // 40 MHz clock
   initial forever #12.5 hclk = ~hclk;
   host_touch_input #(.N_TOUCH(5)) dut_u (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
   host_mcu_model host_u (.hclk(hclk), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task rc(input [21:0] a, input [31:0] e);
      begin
         host_u.rd(a, r);
         chk(r, e);
      end
   endtask
   // Irq is looked at mid-cycle, once the write has landed
   task irqchk(input e);
      begin
         @(negedge hclk);
         chk({31'h0, irq}, {31'h0, e});
         @(posedge hclk);
      end
   endtask
   // Bounded poll for ack; 500 reads stay far below 1 ms
   task waitack;
      begin
         r = 32'h0;
         for (n = 0; n < 500 && r !== 32'h1; n = n + 1)
            host_u.rd(`ADDR_TOUCH_ACK, r);
         chk(r, 32'h1);
      end
   endtask
   task t_regs;
      begin
         rc(`ADDR_TOUCH_ACK, 32'h1);
         rc(`ADDR_TOUCH_X_RAW, 32'h8000);
         host_u.wr(`ADDR_TOUCH_ACK, 32'h5);
         rc(`ADDR_TOUCH_ACK, 32'h1);
         rc(22'h302300, 32'h0);
      end
   endtask
   // Extended mode, ids out of order, id 2 never written
   task t_multi;
      begin
         host_u.enter(1'b1);
         host_u.touch(4'h3, 16'h0123, 16'h0456);
         host_u.touch(4'h0, 16'h0010, 16'h0020);
         host_u.touch(4'h4, 16'hffff, 16'h0001);
         host_u.touch(4'h1, `NO_TOUCH, `NO_TOUCH);
         rc(`ADDR_TOUCH_Y_RAW, 32'h8000);
         rc(`ADDR_RESULT_BASE + 22'hc, 32'h80008000);
         host_u.wr(`ADDR_IRQ_MASK, 32'h1);
         host_u.commit;
         rc(`ADDR_TOUCH_ACK, 32'h0);
         rc(`ADDR_RESULT_BASE, 32'h80008000);
         waitack;
         irqchk(1'b1);
         rc(`ADDR_RESULT_BASE, 32'h00100020);
         rc(`ADDR_RESULT_BASE + 22'h4, 32'h80008000);
         rc(`ADDR_RESULT_BASE + 22'h8, 32'h80008000);
         rc(`ADDR_RESULT_BASE + 22'hc, 32'h01230456);
         rc(`ADDR_RESULT_LAST, 32'hffff0001);
         host_u.wr(`ADDR_IRQ_STATUS, 32'h1);
         irqchk(1'b0);
      end
   endtask
   // Compatibility mode, masked flag, then a slow empty set
   task t_compat;
      begin
         host_u.enter(1'b0);
         host_u.wr(`ADDR_IRQ_MASK, 32'h0);
         host_u.touch(4'h0, 16'h0aaa, 16'h0bbb);
         host_u.commit;
         repeat (28) @(posedge hclk);
         rc(`ADDR_TOUCH_ACK, 32'h1);
         rc(`ADDR_RESULT_BASE, 32'h0aaa0bbb);
         rc(`ADDR_RESULT_BASE + 22'h4, 32'h80008000);
         rc(`ADDR_IRQ_STATUS, 32'h1);
         irqchk(1'b0);
         host_u.wr(`ADDR_IRQ_MASK, 32'h1);
         irqchk(1'b1);
         host_u.wr(`ADDR_IRQ_STATUS, 32'h1);
         irqchk(1'b0);
         host_u.gap = 3;
         host_u.touch(4'h0, `NO_TOUCH, `NO_TOUCH);
         host_u.commit;
         waitack;
         rc(`ADDR_RESULT_BASE, 32'h80008000);
      end
   endtask
   task final_report;
      begin
         $display("checked %0d num_errors %0d", checked, num_errors);
         if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Main sequence after two cycles of reset
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_multi;
      t_compat;
      final_report;
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #500000;
      num_errors = num_errors + 1;
      final_report;
   end
endmodule // host_touch_input_tb_top
